// file: hdl/dsg_map.vh
// Purpose: Constants for the deep-sleep clock gating control block.
// Assumes: APB register bus with 32-bit data, one aligned word per register.
// Notes: Units are indexed 0 = ADC0, 1 = hibernation, 2 = watchdog, 3 = CAN unit 0.
// Contract
// - Each gating bit is one unit clock enable.
// - Access to gated unit raises bus fault.
// - Gating register resets to 0x00000040.
// - Deep-sleep gating register sits at 0x120.
// - Sleep registers apply only with auto gating.
// - Bit 16 enables ADC0 clock, reset 0.
// - Bit 6 enables hibernation clock, reset 1.
// - Bit 3 enables watchdog clock, reset 0.
// - Reserved bits read zero, writes ignored.
// - Bit 24 enables CAN unit 0 clock, reset 0.
`ifndef DSG_MAP_VH
`define DSG_MAP_VH

`define DSG_OFF_RUN_GATE 12'h100
`define DSG_OFF_SLEEP_GATE 12'h110
`define DSG_OFF_DEEP_GATE 12'h120
`define DSG_OFF_RUN_CFG 12'h060
`define DSG_OFF_FAULT_STAT 12'h150
`define DSG_OFF_FAULT_MASK 12'h154

`define DSG_GATE_RESET 32'h00000040
`define DSG_RUN_CFG_RESET 32'h00000000
`define DSG_GATE_IMPL 32'h01010048
`define DSG_RUN_CFG_IMPL 32'h08000000

`define DSG_BIT_ADC 16
`define DSG_BIT_HIBERNATE 6
`define DSG_BIT_WATCHDOG 3
`define DSG_BIT_CAN 24
`define DSG_BIT_AUTO_GATE 27

`define DSG_NUM_UNITS 4

`endif

// file: hdl/dsg_gate_reg.v
// Purpose: One software-written register with byte strobes and a fixed set of writable bits.
// Assumes: Write strobe is a one-cycle pulse on the completing APB edge.
// Notes: Bits outside IMPL never store a value and read as zero.
`timescale 1ns/10ps
`default_nettype none
module dsg_gate_reg #(
	parameter [31:0] RESET = 32'h00000000,
	parameter [31:0] IMPL = 32'hffffffff
) (
	input wire clk,
	input wire rst,
	input wire wr,
	input wire [3:0] strb,
	input wire [31:0] wdata,
	output wire [31:0] value
);
	reg [31:0] value_r;
	reg [31:0] value_nxt;
	integer i;

	always @* begin
		value_nxt = value_r;
		if (wr) begin
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					value_nxt[i*8 +: 8] = wdata[i*8 +: 8];
				end
			end
		end
		value_nxt = value_nxt & IMPL;
	end

	always @(posedge clk) begin
		if (rst) begin
			value_r <= RESET & IMPL;
		end else begin
			value_r <= value_nxt;
		end
	end

	assign value = value_r;
endmodule
`default_nettype wire

// file: hdl/dsg_fault_irq.v
// Purpose: Sticky fault status, mask and level interrupt.
// Assumes: Clear mask holds exactly the bits that software was shown by the read.
// Notes: A new fault in the clearing cycle survives, since set is applied after clear.
`include "dsg_map.vh"
`timescale 1ns/10ps
`default_nettype none
module dsg_fault_irq (
	input wire clk,
	input wire rst,
	input wire [31:0] set,
	input wire clr,
	input wire [31:0] clr_bits,
	input wire mask_wr,
	input wire [31:0] mask_wdata,
	output wire [31:0] status,
	output wire [31:0] mask,
	output wire irq_nxt
);
	reg [31:0] status_r;
	reg [31:0] status_nxt;
	reg [31:0] mask_r;

	always @* begin
		status_nxt = status_r;
		if (clr) begin
			status_nxt = status_nxt & ~clr_bits;
		end
		status_nxt = (status_nxt | set) & `DSG_GATE_IMPL;
	end

	always @(posedge clk) begin
		if (rst) begin
			status_r <= 32'h00000000;
			mask_r <= 32'h00000000;
		end else begin
			status_r <= status_nxt;
			if (mask_wr) begin
				mask_r <= mask_wdata & `DSG_GATE_IMPL;
			end
		end
	end

	assign status = status_r;
	assign mask = mask_r;
	assign irq_nxt = |(status_nxt & (mask_wr ? (mask_wdata & `DSG_GATE_IMPL) : mask_r));
endmodule
`default_nettype wire

// file: hdl/dsg_clock_gate.v
// Purpose: Clock gating control for the deep-sleep, sleep and run modes, with bus fault detection.
// Assumes: Mode and unit access inputs come from logic on CORE_CLK.
// Notes: Enables are registered, so a register write reaches the units one cycle after it completes.
`include "dsg_map.vh"
`timescale 1ns/10ps
`default_nettype none
module dsg_clock_gate (
	input wire CORE_CLK,
	input wire SYS_RST,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [3:0] PSTRB,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	input wire SLEEP_MODE,
	input wire DEEP_SLEEP_MODE,
	input wire [3:0] UNIT_ACCESS,
	output reg [3:0] UNIT_CLK_EN,
	output reg [3:0] UNIT_BUS_FAULT,
	output reg IRQ
);
	localparam [1:0] MODE_RUN = 2'h0;
	localparam [1:0] MODE_SLEEP = 2'h1;
	localparam [1:0] MODE_DEEP = 2'h2;

	wire [31:0] run_clock_gate_0;
	wire [31:0] sleep_clock_gate_0;
	wire [31:0] deep_sleep_clock_gate_0;
	wire [31:0] run_clock_config;
	wire [31:0] fault_status;
	wire [31:0] fault_mask;
	wire irq_nxt;
	wire auto_clock_gating_select;
	wire access_phase;
	wire xfer;
	wire wr_xfer;
	wire rd_xfer;
	wire hit;
	reg [1:0] mode_nxt;
	reg [3:0] clk_en_nxt;
	wire [3:0] fault_nxt;
	wire [31:0] fault_set;
	reg [31:0] rdata_nxt;
	reg stat_read_r;
	genvar u;

	// Maps the four implemented gating bits of a register word onto unit order.
	function [3:0] unit_enables;
		input [31:0] word;
		begin
			unit_enables[0] = word[`DSG_BIT_ADC];
			unit_enables[1] = word[`DSG_BIT_HIBERNATE];
			unit_enables[2] = word[`DSG_BIT_WATCHDOG];
			unit_enables[3] = word[`DSG_BIT_CAN];
		end
	endfunction

	// Places unit-ordered bits back at their register positions.
	function [31:0] unit_to_word;
		input [3:0] units;
		begin
			unit_to_word = 32'h00000000;
			unit_to_word[`DSG_BIT_ADC] = units[0];
			unit_to_word[`DSG_BIT_HIBERNATE] = units[1];
			unit_to_word[`DSG_BIT_WATCHDOG] = units[2];
			unit_to_word[`DSG_BIT_CAN] = units[3];
		end
	endfunction

	// True when the address names a mapped register.
	function addr_mapped;
		input [11:0] addr;
		begin
			if (addr == `DSG_OFF_RUN_GATE) begin
				addr_mapped = 1'b1;
			end else if (addr == `DSG_OFF_SLEEP_GATE) begin
				addr_mapped = 1'b1;
			end else if (addr == `DSG_OFF_DEEP_GATE) begin
				addr_mapped = 1'b1;
			end else if (addr == `DSG_OFF_RUN_CFG) begin
				addr_mapped = 1'b1;
			end else if (addr == `DSG_OFF_FAULT_STAT) begin
				addr_mapped = 1'b1;
			end else if (addr == `DSG_OFF_FAULT_MASK) begin
				addr_mapped = 1'b1;
			end else begin
				addr_mapped = 1'b0;
			end
		end
	endfunction

	// One wait state: PREADY rises in the second access cycle, which gives the read mux a full cycle.
	assign access_phase = PSEL & PENABLE;
	assign xfer = access_phase & PREADY;
	assign hit = addr_mapped(PADDR);
	assign wr_xfer = xfer & PWRITE & hit;
	assign rd_xfer = xfer & ~PWRITE & hit;

	dsg_gate_reg #(
		.RESET(`DSG_GATE_RESET),
		.IMPL(`DSG_GATE_IMPL)
	) u_run_gate (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.wr(wr_xfer & (PADDR == `DSG_OFF_RUN_GATE)),
		.strb(PSTRB),
		.wdata(PWDATA),
		.value(run_clock_gate_0)
	);

	dsg_gate_reg #(
		.RESET(`DSG_GATE_RESET),
		.IMPL(`DSG_GATE_IMPL)
	) u_sleep_gate (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.wr(wr_xfer & (PADDR == `DSG_OFF_SLEEP_GATE)),
		.strb(PSTRB),
		.wdata(PWDATA),
		.value(sleep_clock_gate_0)
	);

	dsg_gate_reg #(
		.RESET(`DSG_GATE_RESET),
		.IMPL(`DSG_GATE_IMPL)
	) u_deep_gate (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.wr(wr_xfer & (PADDR == `DSG_OFF_DEEP_GATE)),
		.strb(PSTRB),
		.wdata(PWDATA),
		.value(deep_sleep_clock_gate_0)
	);

	dsg_gate_reg #(
		.RESET(`DSG_RUN_CFG_RESET),
		.IMPL(`DSG_RUN_CFG_IMPL)
	) u_run_cfg (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.wr(wr_xfer & (PADDR == `DSG_OFF_RUN_CFG)),
		.strb(PSTRB),
		.wdata(PWDATA),
		.value(run_clock_config)
	);

	assign auto_clock_gating_select = run_clock_config[`DSG_BIT_AUTO_GATE];

	// Deep sleep wins if both mode inputs are high, since it is the stronger request.
	always @* begin
		mode_nxt = MODE_RUN;
		if (auto_clock_gating_select) begin
			if (DEEP_SLEEP_MODE) begin
				mode_nxt = MODE_DEEP;
			end else if (SLEEP_MODE) begin
				mode_nxt = MODE_SLEEP;
			end
		end
	end

	always @* begin
		case (mode_nxt)
			MODE_SLEEP: begin
				clk_en_nxt = unit_enables(sleep_clock_gate_0);
			end
			MODE_DEEP: begin
				clk_en_nxt = unit_enables(deep_sleep_clock_gate_0);
			end
			default: begin
				clk_en_nxt = unit_enables(run_clock_gate_0);
			end
		endcase
	end

	always @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			UNIT_CLK_EN <= unit_enables(`DSG_GATE_RESET);
		end else begin
			UNIT_CLK_EN <= clk_en_nxt;
		end
	end

	// The check uses the enables that the units are actually seeing this cycle.
	generate
		for (u = 0; u < `DSG_NUM_UNITS; u = u + 1) begin : g_unit_fault
			assign fault_nxt[u] = UNIT_ACCESS[u] & ~UNIT_CLK_EN[u];
		end
	endgenerate

	assign fault_set = unit_to_word(fault_nxt);

	always @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			UNIT_BUS_FAULT <= 4'h0;
		end else begin
			UNIT_BUS_FAULT <= fault_nxt;
		end
	end

	// Reading status clears only the bits returned, so a fault arriving meanwhile stays visible.
	dsg_fault_irq u_fault_irq (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.set(fault_set),
		.clr(rd_xfer & stat_read_r),
		.clr_bits(PRDATA),
		.mask_wr(wr_xfer & (PADDR == `DSG_OFF_FAULT_MASK)),
		.mask_wdata(PWDATA),
		.status(fault_status),
		.mask(fault_mask),
		.irq_nxt(irq_nxt)
	);

	always @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= irq_nxt;
		end
	end

	always @* begin
		if (PADDR == `DSG_OFF_RUN_GATE) begin
			rdata_nxt = run_clock_gate_0;
		end else if (PADDR == `DSG_OFF_SLEEP_GATE) begin
			rdata_nxt = sleep_clock_gate_0;
		end else if (PADDR == `DSG_OFF_DEEP_GATE) begin
			rdata_nxt = deep_sleep_clock_gate_0;
		end else if (PADDR == `DSG_OFF_RUN_CFG) begin
			rdata_nxt = run_clock_config;
		end else if (PADDR == `DSG_OFF_FAULT_STAT) begin
			rdata_nxt = fault_status;
		end else if (PADDR == `DSG_OFF_FAULT_MASK) begin
			rdata_nxt = fault_mask;
		end else begin
			rdata_nxt = 32'h00000000;
		end
	end

	always @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h00000000;
			stat_read_r <= 1'b0;
		end else begin
			PREADY <= access_phase & ~PREADY;
			PSLVERR <= access_phase & ~PREADY & ~hit;
			stat_read_r <= access_phase & ~PREADY & ~PWRITE & (PADDR == `DSG_OFF_FAULT_STAT);
			if (access_phase & ~PREADY & ~PWRITE) begin
				PRDATA <= rdata_nxt & `DSG_GATE_IMPL | rdata_nxt & `DSG_RUN_CFG_IMPL;
			end else if (xfer) begin
				PRDATA <= 32'h00000000;
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/dsg_chk.sv
// Purpose: Port assertions for the deep-sleep clock gating block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Enable changes are traced back to a completed write or a mode step.
`timescale 1ns/10ps
`default_nettype none
module dsg_chk (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic SLEEP_MODE,
	input wire logic DEEP_SLEEP_MODE,
	input wire logic [3:0] UNIT_ACCESS,
	input wire logic [3:0] UNIT_CLK_EN,
	input wire logic [3:0] UNIT_BUS_FAULT,
	input wire logic IRQ
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	ready_timing_a: assert property (PSEL && !PENABLE |-> ##2 PREADY) else $error("ready not in second access cycle");
	ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held too long");
	ready_cause_a: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && PENABLE)) else $error("ready without access");
	slverr_map_a: assert property (PREADY |-> PSLVERR == !(PADDR inside {12'h060, 12'h100, 12'h110, 12'h120, 12'h150, 12'h154}))
		else $error("error response wrong");
	idle_data_a: assert property (!PREADY |-> PRDATA == 32'h0) else $error("read data outside answer");
	fault_pulse_a: assert property (1'b1 |=> UNIT_BUS_FAULT == $past(UNIT_ACCESS & ~UNIT_CLK_EN))
		else $error("fault pulse wrong");
	reset_state_a: assert property (disable iff (1'b0) SYS_RST |=> UNIT_CLK_EN == 4'h2 && !IRQ && !PREADY)
		else $error("reset state wrong");
	enable_cause_a: assert property ($changed(UNIT_CLK_EN) |-> $past(PREADY && PWRITE) ||
		$past(PREADY && PWRITE, 2) || $past({SLEEP_MODE, DEEP_SLEEP_MODE}) != $past({SLEEP_MODE, DEEP_SLEEP_MODE}, 2))
		else $error("enable moved");
endmodule
bind dsg_clock_gate dsg_chk dsg_chk_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP_MODE(SLEEP_MODE),
	.DEEP_SLEEP_MODE(DEEP_SLEEP_MODE), .UNIT_ACCESS(UNIT_ACCESS), .UNIT_CLK_EN(UNIT_CLK_EN),
	.UNIT_BUS_FAULT(UNIT_BUS_FAULT), .IRQ(IRQ));
`default_nettype wire

// file: verification/dsg_units.sv
// Purpose: Gated units that address their bus on request and tally faults.
// Assumes: Requests come from the bench on the core clock.
// Notes: A gated unit is still addressed, since that is the case to provoke.
`timescale 1ns/10ps
`default_nettype none
module dsg_units (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] req,
	input wire logic [3:0] fault,
	output logic [3:0] access,
	output logic [7:0] faults_seen
);
	always @(posedge clk) begin
		access <= rst ? 4'h0 : req;
		faults_seen <= rst ? 8'h0 : faults_seen + 8'($countones(fault));
	end
endmodule
`default_nettype wire

// file: verification/dsg_clock_gate_test.sv
// Purpose: Self-checking bench for the clock gating block.
// Assumes: Exactly one wait state per transfer, enables visible two cycles after a write.
// Notes: Random data come from a fixed-seed shift register.
`timescale 1ns/10ps
`default_nettype none
module dsg_clock_gate_test;
	logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, sleep_mode = 0, deep_mode = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rnd, rd, prev;
	logic [3:0] pstrb = 0, req = 0, access, clk_en, fault, g;
	logic [7:0] faults_seen, cnt;
	logic irq, err;
	int fails = 0, checks_done = 0;
	always #5 core_clk = ~core_clk;
	dsg_clock_gate dsg_clock_gate_inst (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .SLEEP_MODE(sleep_mode), .DEEP_SLEEP_MODE(deep_mode), .UNIT_ACCESS(access),
		.UNIT_CLK_EN(clk_en), .UNIT_BUS_FAULT(fault), .IRQ(irq));
	dsg_units dsg_units_inst (.clk(core_clk), .rst(sys_rst), .req(req), .fault(fault), .access(access),
		.faults_seen(faults_seen));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [31:0] stat_bits(input logic [3:0] u);
		return {7'h0, u[3], 7'h0, u[0], 9'h0, u[1], 2'h0, u[2], 3'h0};
	endfunction
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, wr, a, d, s};
		@(posedge core_clk);
		penable <= 1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fails++;
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
		apb(0, a, 32'h0, 4'h0);
		check("read data", rd, exp);
		check("error flag", 32'(err), 32'(experr));
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge core_clk);
		fails++;
		complete_run;
	end
	initial begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 0;
		rnd = 32'h8fac;
		rdchk(12'h120, 32'h40, 0);
		check("enables after reset", 32'(clk_en), 32'h2);
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			apb(1, 12'h100 + 12'(i * 16), rnd, 4'hf);
			rdchk(12'h100 + 12'(i * 16), rnd & 32'h01010048, 0);
		end
		prev = rnd & 32'h01010048;
		apb(1, 12'h120, 32'hffffffff, 4'h1);
		rdchk(12'h120, {prev[31:8], 8'h48}, 0);
		apb(1, 12'h124, 32'hffffffff, 4'hf);
		check("unmapped write error", 32'(err), 32'h1);
		rdchk(12'h124, 32'h0, 1);
		$display("register test done");
		apb(1, 12'h120, 32'h01000008, 4'hf);
		apb(1, 12'h100, 32'h00010000, 4'hf);
		apb(1, 12'h110, 32'h00000040, 4'hf);
		deep_mode <= 1;
		repeat (3) @(posedge core_clk);
		check("enables without auto gating", 32'(clk_en), 32'h1);
		apb(1, 12'h060, 32'h08000000, 4'hf);
		repeat (3) @(posedge core_clk);
		check("deep sleep enables", 32'(clk_en), 32'hc);
		{deep_mode, sleep_mode} <= 2'b01;
		repeat (3) @(posedge core_clk);
		check("sleep enables", 32'(clk_en), 32'h2);
		{deep_mode, sleep_mode} <= 2'b11;
		repeat (3) @(posedge core_clk);
		check("deep over sleep enables", 32'(clk_en), 32'hc);
		$display("mode test done");
		apb(1, 12'h154, 32'hffffffff, 4'h0);
		rdchk(12'h154, 32'h01010048, 0);
		g = 0;
		cnt = 0;
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			@(posedge core_clk);
			req <= rnd[3:0] | 4'h1;
			g = g | ((rnd[3:0] | 4'h1) & 4'h3);
			cnt = cnt + 8'($countones((rnd[3:0] | 4'h1) & 4'h3));
			@(posedge core_clk);
			req <= 0;
		end
		repeat (3) @(posedge core_clk);
		check("interrupt raised", 32'(irq), 32'h1);
		check("fault count", 32'(faults_seen), 32'(cnt));
		rdchk(12'h150, stat_bits(g), 0);
		repeat (3) @(posedge core_clk);
		check("interrupt cleared", 32'(irq), 32'h0);
		{deep_mode, sleep_mode} <= 2'b00;
		apb(1, 12'h154, 32'h0, 4'hf);
		@(posedge core_clk);
		req <= 4'h8;
		@(posedge core_clk);
		req <= 4'h4;
		@(posedge core_clk);
		req <= 0;
		repeat (3) @(posedge core_clk);
		check("masked interrupt", 32'(irq), 32'h0);
		check("masked fault count", 32'(faults_seen), 32'(cnt) + 32'h2);
		rdchk(12'h150, 32'h01000008, 0);
		$display("fault test done");
		complete_run;
	end
endmodule
`default_nettype wire
